// *** swcl_host.sv ***
// Host controller end: APB registers and serial word sender
`default_nettype none
module swcl_host (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  swcl_if.host link
);
  import swcl_pkg::*;

  swcl_host_e state_q; // Sender state
  logic [15:0] word_q; // Bits left to send, MSB first
  logic [4:0] bits_q; // Count of bits left
  logic [7:0] div_q; // Step divider, four clocks per step
  logic [31:0] pins_q; // Preset and shutdown levels
  logic [31:0] chain_in_q; // Bits seen on the chain output
  logic [1:0] chain_sync_q; // Synchroniser for the chain output

  wire acc = psel & penable;
  wire wr_cmd = acc & pwrite & (paddr == SWCL_OFS_CMD);
  wire wr_pins = acc & pwrite & (paddr == SWCL_OFS_PINS);
  wire mapped = (paddr == SWCL_OFS_CMD) | (paddr == SWCL_OFS_STATUS) |
                (paddr == SWCL_OFS_PINS);
  wire busy = (state_q != SWCL_IDLE);
  wire half_done = (div_q == 8'(SWCL_SCLK_HALF_CYC - 1));
  wire [4:0] req_len = pwdata[SWCL_CMD_LEN_LSB +: SWCL_CMD_LEN_W];
  // Nine-bit word: address then code; other lengths drop the address
  wire [15:0] req_word = {pwdata[SWCL_CMD_ADDR_BIT],
                          pwdata[SWCL_CMD_CODE_LSB +: 8], 7'h00};
  wire [31:0] rd_mux = (paddr == SWCL_OFS_STATUS) ? {31'h0, busy} :
                       (paddr == SWCL_OFS_PINS) ? pins_q :
                       (paddr == SWCL_OFS_CMD) ? chain_in_q : 32'h0;

  // APB answer: one access cycle, command writes while busy are refused
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & (~mapped |
                 (pwrite & busy & (paddr == SWCL_OFS_CMD)));
      prdata <= rd_mux;
    end
  end

  // Preset and shutdown pin levels
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pins_q <= SWCL_PINS_RESET;
    end else if (wr_pins && pready) begin
      pins_q <= pwdata;
    end
  end

  // Sender: cs low, bits change midway through sclk low, cs high ends the frame
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= SWCL_IDLE;
      word_q <= '0;
      bits_q <= '0;
      div_q <= '0;
      link.sclk <= 1'b0;
      link.cs_n <= 1'b1;
      link.serial_in <= 1'b0;
    end else begin
      div_q <= half_done ? 8'h00 : div_q + 8'h01;
      unique case (state_q)
        SWCL_IDLE: begin
          div_q <= '0;
          // One frame per word, length 1 to 31
          if (wr_cmd && pready && !pslverr && req_len != 5'h0) begin
            word_q <= (req_len == 5'd9) ? req_word : {req_word[14:0], 1'b0};
            bits_q <= req_len;
            link.cs_n <= 1'b0;
            state_q <= SWCL_LOW;
          end
        end
        SWCL_LOW: begin
          if (half_done) begin
            if (bits_q == 5'h0) begin
              state_q <= SWCL_DONE;
            end else begin
              link.serial_in <= word_q[15];
              word_q <= {word_q[14:0], 1'b0};
              bits_q <= bits_q - 5'h1;
              state_q <= SWCL_HIGH;
            end
          end
        end
        SWCL_HIGH: begin
          if (half_done) begin
            link.sclk <= ~link.sclk; // Divider-made serial clock
            state_q <= link.sclk ? SWCL_LOW : SWCL_HIGH;
          end
        end
        SWCL_DONE: begin
          link.cs_n <= 1'b1;
          link.sclk <= 1'b0;
          state_q <= SWCL_IDLE;
        end
      endcase
    end
  end

  // Capture the chain output on each rising sclk
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      chain_sync_q <= 2'b11;
      chain_in_q <= '0;
    end else begin
      chain_sync_q <= {chain_sync_q[0], link.chain_serial_out};
      if (state_q == SWCL_HIGH && half_done && !link.sclk) begin
        chain_in_q <= {chain_in_q[30:0], chain_sync_q[1]};
      end
    end
  end

  assign link.midscale_preset_n = pins_q[SWCL_PIN_PRESET];
  assign link.power_down_n = pins_q[SWCL_PIN_PDOWN];
endmodule : swcl_host
`default_nettype wire

// *** swcl_pkg.sv ***
// Package of constants and types shared by both ends of the wiper link
`default_nettype none
package swcl_pkg;
  localparam int SWCL_CODE_W = 8;
  localparam int SWCL_WORD_W = 9;
  localparam int SWCL_TAPS = 256;
  localparam logic [7:0] SWCL_MIDSCALE = 8'h80;
  localparam int SWCL_CLK_NS = 10;
  // Step of the host-made serial clock: sclk high one step, low two, 120 ns full period
  localparam int SWCL_SCLK_HALF_NS = 40;
  localparam int SWCL_SCLK_HALF_CYC = SWCL_SCLK_HALF_NS / SWCL_CLK_NS;
  // APB register offsets of the host controller
  localparam logic [7:0] SWCL_OFS_CMD = 8'h00;
  localparam logic [7:0] SWCL_OFS_STATUS = 8'h04;
  localparam logic [7:0] SWCL_OFS_PINS = 8'h08;
  // Command register fields
  localparam int SWCL_CMD_CODE_LSB = 0;
  localparam int SWCL_CMD_ADDR_BIT = 8;
  localparam int SWCL_CMD_LEN_LSB = 16;
  localparam int SWCL_CMD_LEN_W = 5;
  // Pins register fields
  localparam int SWCL_PIN_PRESET = 0;
  localparam int SWCL_PIN_PDOWN = 1;
  localparam logic [31:0] SWCL_PINS_RESET = 32'h0000_0003;
  localparam int SWCL_ST_BUSY = 0;
  typedef enum logic [1:0] {SWCL_IDLE, SWCL_LOW, SWCL_HIGH, SWCL_DONE}
    swcl_host_e;
endpackage : swcl_pkg
`default_nettype wire

// *** swcl_if.sv ***
// Interface joining the host controller and the wiper device
`default_nettype none
interface swcl_if;
  logic sclk;
  logic cs_n;
  logic serial_in;
  logic midscale_preset_n;
  logic power_down_n;
  logic chain_serial_out_o;
  logic chain_serial_out_oe;
  // Open-drain line with pull-up: low only while driven
  wire chain_serial_out = chain_serial_out_oe ? chain_serial_out_o : 1'b1;
  modport host (output sclk, cs_n, serial_in, midscale_preset_n,
                power_down_n, input chain_serial_out);
  modport device (input sclk, cs_n, serial_in, midscale_preset_n,
                  power_down_n, output chain_serial_out_o,
                  chain_serial_out_oe);
endinterface : swcl_if
`default_nettype wire

// *** swcl_device.sv ***
// Wiper device end: shift register, wiper latches, tap decode
`default_nettype none
module swcl_device #(
  parameter bit DUAL = 1'b1 // Two-channel variant when set
) (
  input wire logic clk,
  input wire logic reset,
  swcl_if.device link,
  output logic [swcl_pkg::SWCL_CODE_W-1:0] wiper_latch_ch1,
  output logic [swcl_pkg::SWCL_CODE_W-1:0] wiper_latch_ch2,
  output logic [swcl_pkg::SWCL_TAPS-1:0] tap_onehot_ch1,
  output logic [swcl_pkg::SWCL_TAPS-1:0] tap_onehot_ch2,
  output logic terminal_a_open
);
  import swcl_pkg::*;

  // Overview of timing, from pin to latch
  // Every link pin is sampled by the system clock
  // Two flops per pin before any logic reads it
  // Synced levels feed the edge finders below
  // Edge finders compare synced level with last cycle
  // Shift happens one clock after the synced rise
  // Pin to shift register: three system clocks
  // Pin to latch register: three system clocks
  // Pin to latch output port: four system clocks
  // Serial clock phases must each span three clocks
  // Shorter phases would let an edge slip past
  // Host divider gives four clocks high, eight low
  // That leaves one spare clock of margin

  // Overview of frame handling
  // Chip select low opens a frame
  // Each synced rise of sclk shifts one bit
  // Bits enter at the low end, oldest at the top
  // Nine bits held, so extra early bits drop off
  // Chip select rise closes the frame
  // Closing edge copies the held word to one latch
  // Top bit picks the latch in the dual part
  // Single part always loads the first latch
  // A frame with fewer bits loads stale upper bits
  // Host must therefore send full words

  // Overview of preset
  // Preset low forces both latches to midscale
  // Preset low also clears the output latch
  // Preset low blocks shifting and loading
  // Preset rise with chip select high reloads midscale
  // Shift register itself is left as it was
  // A frame sent across a preset edge is lost

  // Overview of shutdown
  // Shutdown only changes the outputs: taps, A flag, serial out
  // Latches keep their codes through shutdown
  // Tap zero alone is closed, wiper at the B end
  // A terminals reported open on a separate port
  // Serial output released for the whole shutdown
  // Release of shutdown shows the kept codes again
  // Loads during shutdown still update the latches

  // Overview of the chain output
  // Output latch holds the bit from eight shifts back
  // Open drain: only a zero pulls the line down
  // A one, or a disabled output, leaves the pull-up
  // Output only enabled while chip select is low
  // Deselected devices thus never load the line
  // Next device in a chain samples on its own clock
  // Far device sees data one word behind the near one

  // Overview of reset
  // Asynchronous reset puts both latches at midscale
  // Synchronisers reset to the idle pin levels
  // That keeps a false edge away after reset
  // Outputs reset to the midscale tap as well

  // Limitations
  // No check that a frame held nine bits
  // No readback of the shift register by the host
  // Only the chain output shows what was shifted
  // Tap outputs are wide, one bit per position
  // Decode is a plain one-hot, no glitch filter
  // All outputs registered; latch and tap ports one clock after latches

  // One-hot tap select for a code
  function automatic logic [SWCL_TAPS-1:0] tap_dec(input logic [7:0] c);
    tap_dec = '0;
    tap_dec[c] = 1'b1;
  endfunction

  // Two-flop synchronisers for the pins
  logic [4:0] s1_q;
  logic [4:0] s2_q;
  logic sclk_prev_q; // Last synced sclk, for edge finding
  logic cs_prev_q; // Last synced cs_n
  logic pre_prev_q; // Last synced preset
  logic [SWCL_WORD_W-1:0] input_shift_register_q; // Shift chain
  logic out_bit_q; // Serial output latch
  logic [7:0] wiper_latch_ch1_q;
  logic [7:0] wiper_latch_ch2_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      // Idle levels: sclk low, cs high, data low, preset, pdown high
      s1_q <= 5'h0B;
      s2_q <= 5'h0B;
    end else begin
      s1_q <= {link.sclk, link.cs_n, link.serial_in,
               link.midscale_preset_n, link.power_down_n};
      s2_q <= s1_q;
    end
  end

  // Named views of the synced pins
  wire sclk_s = s2_q[4];
  wire cs_n_s = s2_q[3];
  wire serial_in_s = s2_q[2];
  wire pre_n_s = s2_q[1];
  wire pdn_n_s = s2_q[0];
  wire sclk_rise = sclk_s & ~sclk_prev_q;
  wire shift_en = sclk_rise & ~cs_n_s & pre_n_s;
  wire load_en = cs_n_s & ~cs_prev_q & pre_n_s;
  wire pre_rise = pre_n_s & ~pre_prev_q & cs_n_s;
  // Address bit sits at the ninth position after nine shifts
  wire addr_bit = DUAL ? input_shift_register_q[8] : 1'b0;
  wire [7:0] code_word = input_shift_register_q[7:0];

  // Edge history
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
      pre_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s;
      cs_prev_q <= cs_n_s;
      pre_prev_q <= pre_n_s;
    end
  end

  // Shift register; older bits fall off so only the last nine stay
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      input_shift_register_q <= '0;
    end else if (shift_en) begin
      input_shift_register_q <= {input_shift_register_q[7:0], serial_in_s};
    end
  end

  // Output latch takes the bit that entered eight shifts ago
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      out_bit_q <= 1'b0;
    end else if (!pre_n_s) begin
      out_bit_q <= 1'b0;
    end else if (shift_en) begin
      out_bit_q <= input_shift_register_q[7];
    end
  end

  // Wiper latches; preset wins over any load
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wiper_latch_ch1_q <= SWCL_MIDSCALE;
      wiper_latch_ch2_q <= SWCL_MIDSCALE;
    end else if (!pre_n_s || pre_rise) begin
      wiper_latch_ch1_q <= SWCL_MIDSCALE;
      wiper_latch_ch2_q <= SWCL_MIDSCALE;
    end else if (load_en) begin
      if (!addr_bit) begin
        wiper_latch_ch1_q <= code_word;
      end else begin
        wiper_latch_ch2_q <= code_word;
      end
    end
  end

  // Registered outputs; shutdown parks taps at the B end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wiper_latch_ch1 <= SWCL_MIDSCALE;
      wiper_latch_ch2 <= SWCL_MIDSCALE;
      tap_onehot_ch1 <= tap_dec(SWCL_MIDSCALE);
      tap_onehot_ch2 <= tap_dec(SWCL_MIDSCALE);
      terminal_a_open <= 1'b0;
      link.chain_serial_out_o <= 1'b0;
      link.chain_serial_out_oe <= 1'b0;
    end else begin
      wiper_latch_ch1 <= wiper_latch_ch1_q;
      wiper_latch_ch2 <= wiper_latch_ch2_q;
      // Wiper tied to B in shutdown, tap 0 alone closed
      // Exactly one tap closed
      tap_onehot_ch1 <= tap_dec(pdn_n_s ? wiper_latch_ch1_q : 8'h00);
      // Shutdown parks both wipers
      tap_onehot_ch2 <= tap_dec(pdn_n_s ? wiper_latch_ch2_q : 8'h00);
      terminal_a_open <= ~pdn_n_s;
      link.chain_serial_out_o <= 1'b0;
      // Pull low only for a zero bit while cs low and not shut down
      link.chain_serial_out_oe <= pdn_n_s & ~cs_n_s & ~out_bit_q;
    end
  end
endmodule : swcl_device
`default_nettype wire

// *** swcl_asserts.sv ***
// Checker watching the wiper link between host and device
`default_nettype none
module swcl_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_in,
  input wire logic midscale_preset_n,
  input wire logic power_down_n,
  input wire logic chain_serial_out_o,
  input wire logic chain_serial_out_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // One serial clock high phase of four cycles, then low
  sequence s_high_phase;
    sclk [*4] ##1 !sclk;
  endsequence
  chk_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("serial clock moved outside a frame");
  chk_bit_setup: assert property (
      $rose(sclk) |-> $stable(serial_in) && !cs_n)
    else $error("data moved at a shifting edge");
  chk_high_len: assert property ($rose(sclk) |-> s_high_phase)
    else $error("serial clock high phase wrong");
  chk_frame_open: assert property ($fell(cs_n) |-> !sclk [*2])
    else $error("frame opened with clock high");
  chk_frame_close: assert property ($rose(cs_n) |-> !$past(sclk))
    else $error("frame closed with clock high");
  chk_pdown_off: assert property (
      !power_down_n [*4] |-> !chain_serial_out_oe)
    else $error("serial out driven in shutdown");
  chk_idle_off: assert property (
      cs_n [*4] |-> !chain_serial_out_oe)
    else $error("serial out driven while deselected");
  chk_od_level: assert property (
      chain_serial_out_oe |-> !chain_serial_out_o)
    else $error("open drain drove a high level");
  // Preset pulse seen at least once
  cov_preset: cover property ($rose(midscale_preset_n));
endmodule // swcl_asserts
`default_nettype wire

// *** serial_wiper_code_loader_tb.sv ***
// Testbench driving the host over APB and watching the device
`default_nettype none
module serial_wiper_code_loader_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import swcl_pkg::*;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, err, a_open;
  logic [7:0] paddr, lat1, lat2, e1, e2;
  logic [31:0] pwdata, prdata, rd;
  logic [255:0] tap1, tap2;
  logic [7:0] codes [4] = '{8'h5A, 8'hA5, 8'h00, 8'hFF};
  int failures, n_checks, cycles;
  swcl_if swcl_if_inst ();
  swcl_host swcl_host_inst (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(swcl_if_inst.host));
  swcl_device #(.DUAL(1'b1)) swcl_device_inst (.clk(clk), .reset(reset),
    .link(swcl_if_inst.device), .wiper_latch_ch1(lat1),
    .wiper_latch_ch2(lat2), .tap_onehot_ch1(tap1), .tap_onehot_ch2(tap2),
    .terminal_a_open(a_open));
  swcl_asserts swcl_asserts_inst (.clk(clk), .reset(reset),
    .sclk(swcl_if_inst.sclk), .cs_n(swcl_if_inst.cs_n),
    .serial_in(swcl_if_inst.serial_in),
    .midscale_preset_n(swcl_if_inst.midscale_preset_n),
    .power_down_n(swcl_if_inst.power_down_n),
    .chain_serial_out_o(swcl_if_inst.chain_serial_out_o),
    .chain_serial_out_oe(swcl_if_inst.chain_serial_out_oe));
  // 100 MHz system clock
  always #5 clk = ~clk;
  // Hang guard, far above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      results();
    end
  end
  // Counts, then verdict
  task automatic results;
    $display("Checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [255:0] exp,
                       input logic [255:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // One APB transfer; waits on pready, no assumed latency
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Poll busy, then allow the latch update delay
  task automatic wait_idle;
    rd = 32'h1;
    while (rd[SWCL_ST_BUSY] === 1'b1) apb(1'b0, SWCL_OFS_STATUS, 32'h0);
    repeat (8) @(posedge clk);
  endtask
  // Nine-bit word: address bit then code
  task automatic send(input logic ch, input logic [7:0] code);
    apb(1'b1, SWCL_OFS_CMD, {11'h000, 5'h09, 7'h00, ch, code});
    wait_idle();
  endtask
  // Pin register write; sync, latch and output register delay
  task automatic pins(input logic [31:0] v);
    apb(1'b1, SWCL_OFS_PINS, v);
    repeat (6) @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    check("lat1", SWCL_MIDSCALE, lat1);
    check("lat2", SWCL_MIDSCALE, lat2);
    apb(1'b0, SWCL_OFS_PINS, 32'h0);
    check("pins", SWCL_PINS_RESET, rd);
    $display("test reset done");
    e1 = SWCL_MIDSCALE;
    e2 = SWCL_MIDSCALE;
    // Channel two first, then alternate, boundary codes included
    for (int i = 0; i < 4; i++) begin
      send(~i[0], codes[i]);
      if (i[0]) e1 = codes[i];
      else e2 = codes[i];
      check("lat1", e1, lat1);
      check("lat2", e2, lat2);
      check("tap1", 256'h1 << e1, tap1);
      check("tap2", 256'h1 << e2, tap2);
      // Chain output replays the previous word's code bits
      if (i > 0) begin
        apb(1'b0, SWCL_OFS_CMD, 32'h0);
        check("chain_out", codes[i-1], rd[7:0]);
      end
    end
    $display("test update done");
    pins(32'h1);
    check("a_open", 1'b1, a_open);
    check("tap1", 256'h1, tap1);
    check("lat1", e1, lat1);
    pins(32'h3);
    check("tap1", 256'h1 << e1, tap1);
    check("a_open", 1'b0, a_open);
    $display("test shutdown done");
    pins(32'h2);
    check("lat1", SWCL_MIDSCALE, lat1);
    check("lat2", SWCL_MIDSCALE, lat2);
    pins(32'h3);
    $display("test preset done");
    // Second command while busy is refused
    apb(1'b1, SWCL_OFS_CMD, {16'h0009, 8'h00, 8'h3C});
    apb(1'b1, SWCL_OFS_CMD, {16'h0009, 8'h00, 8'hC3});
    check("busy_err", 1'b1, err);
    wait_idle();
    check("lat1", 8'h3C, lat1);
    apb(1'b0, 8'h0C, 32'h0);
    check("unmapped_err", 1'b1, err);
    $display("test refusal done");
    results();
  end
endmodule // serial_wiper_code_loader_tb
`default_nettype wire
